// ---- rtl/tnx_exec.sv ----
// Executor for nibble swap, table read, latch write and test-skip-zero
`timescale 1ns/1ps
module tnx_exec (
  input  wire logic        CLOCK,
  input  wire logic        ARST_N,
  input  wire logic [15:0] INSTR,
  input  wire logic        INSTR_VALID,
  input  wire logic [7:0]  FILE_RDATA,
  input  wire logic [15:0] PMEM_RDATA,
  output logic      [7:0]  FILE_ADDR,
  output logic             FILE_RE,
  output logic             FILE_WE,
  output logic      [7:0]  FILE_WDATA,
  output logic      [7:0]  WORKING_REGISTER,
  output logic      [15:0] TABLE_LATCH,
  output logic      [15:0] TABLE_POINTER,
  output logic      [15:0] ADDR_BUS,
  output logic             OE_N,
  output logic             BUSY,
  output logic             SKIP
);
  tnx_phase_if ph ();

  tnx_phase_gen u_phase (
    .CLOCK  (CLOCK),
    .ARST_N (ARST_N),
    .ph     (ph.gen)
  );

  typedef struct packed {
    tnx_pkg::tnx_mode_type mode;
    logic [15:0]           ir;
    logic [7:0]            opnd;
    logic [7:0]            res;
    logic [7:0]            faddr;
    logic                  fre;
    logic                  fwe;
    logic [7:0]            fwd;
    logic [7:0]            working_register;
    logic [15:0]           latch;
    logic [15:0]           ptr;
    logic [15:0]           abus;
    logic                  oe_n;
    logic                  busy;
    logic                  skip;
    logic                  extra;
  } tnx_ex_state_type;

  tnx_ex_state_type s_q;
  tnx_ex_state_type s_d;

  logic is_swap;
  logic is_trd;
  logic is_tlw;
  logic is_tst;

  // Opcode decode on the held instruction word
  assign is_swap = (s_q.ir[15:9] == tnx_pkg::TNX_OPC_SWAP);
  assign is_trd  = (s_q.ir[15:10] == tnx_pkg::TNX_OPC_TRD);
  assign is_tlw  = (s_q.ir[15:10] == tnx_pkg::TNX_OPC_TLW);
  assign is_tst  = (s_q.ir[15:8] == tnx_pkg::TNX_OPC_TST);

  // Phase-sequenced execution; strobes are one phase wide
  always_comb begin
    s_d      = s_q;
    s_d.fre  = 1'b0;
    s_d.fwe  = 1'b0;
    s_d.oe_n = 1'b1;
    case (s_q.mode)
      tnx_pkg::TNX_EXEC: begin
        case (ph.phase)
          tnx_pkg::TNX_Q1: begin
            // Decode, or force a nop when nothing valid is offered
            s_d.ir    = INSTR_VALID ? INSTR : tnx_pkg::TNX_WORD_RESET;
            s_d.faddr = INSTR[7:0];
            s_d.fre   = INSTR_VALID;
            s_d.busy  = 1'b0;
            s_d.skip  = 1'b0;
          end
          tnx_pkg::TNX_Q2: begin
            // Table read takes its operand from the latch, not the file
            if (is_trd) begin
              s_d.opnd = s_q.ir[tnx_pkg::TNX_BIT_T] ? s_q.latch[15:8] : s_q.latch[7:0];
            end else begin
              s_d.opnd = FILE_RDATA;
            end
          end
          tnx_pkg::TNX_Q3: begin
            s_d.res = is_swap ? {s_q.opnd[3:0], s_q.opnd[7:4]} : s_q.opnd;
            if (is_tlw) begin
              // Only the selected half moves
              if (s_q.ir[tnx_pkg::TNX_BIT_T]) begin
                s_d.latch[15:8] = s_q.opnd;
              end else begin
                s_d.latch[7:0] = s_q.opnd;
              end
            end
          end
          tnx_pkg::TNX_Q4: begin
            if (is_swap && !s_q.ir[tnx_pkg::TNX_BIT_D]) begin
              s_d.working_register = s_q.res;
            end else if (is_swap || is_trd) begin
              s_d.fwe = 1'b1;
              s_d.fwd = s_q.res;
            end
            if (is_trd) begin
              s_d.mode  = tnx_pkg::TNX_TBL;
              s_d.busy  = 1'b1;
              s_d.extra = (s_q.faddr == tnx_pkg::TNX_ADDR_PCL);
            end else if (is_tst && s_q.opnd == tnx_pkg::TNX_ZERO_BYTE) begin
              s_d.mode = tnx_pkg::TNX_FLUSH;
              s_d.busy = 1'b1;
              s_d.skip = 1'b1;
            end
          end
          default: s_d.mode = tnx_pkg::TNX_EXEC;
        endcase
      end
      tnx_pkg::TNX_TBL: begin
        // Second cycle: pointer on the bus, enable low in Q4
        s_d.abus = s_q.ptr;
        if (ph.phase == tnx_pkg::TNX_Q4) begin
          s_d.oe_n = 1'b1;
        end
        if (ph.phase == tnx_pkg::TNX_Q3) begin
          s_d.oe_n = 1'b0;
        end
        if (ph.phase == tnx_pkg::TNX_Q4) begin
          s_d.latch = PMEM_RDATA;
          if (s_q.ir[tnx_pkg::TNX_BIT_I]) begin
            s_d.ptr = s_q.ptr + tnx_pkg::TNX_PTR_STEP;
          end
          // A write to counter low costs one flush cycle more
          s_d.mode = s_q.extra ? tnx_pkg::TNX_FLUSH : tnx_pkg::TNX_EXEC;
          s_d.busy = s_q.extra;
          s_d.extra = 1'b0;
        end
      end
      tnx_pkg::TNX_FLUSH: begin
        // Fetched word is dropped; a nop cycle runs in its place
        if (ph.cycle_end) begin
          s_d.mode = tnx_pkg::TNX_EXEC;
          s_d.busy = 1'b0;
          s_d.skip = 1'b0;
        end
      end
      default: s_d.mode = tnx_pkg::TNX_EXEC;
    endcase
  end

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      s_q      <= '0;
      s_q.mode <= tnx_pkg::TNX_EXEC;
      s_q.oe_n <= 1'b1;
      s_q.working_register <= tnx_pkg::TNX_WORKING_REGISTER_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign FILE_ADDR     = s_q.faddr;
  assign FILE_RE       = s_q.fre;
  assign FILE_WE       = s_q.fwe;
  assign FILE_WDATA    = s_q.fwd;
  assign WORKING_REGISTER          = s_q.working_register;
  assign TABLE_LATCH   = s_q.latch;
  assign TABLE_POINTER = s_q.ptr;
  assign ADDR_BUS      = s_q.abus;
  assign OE_N          = s_q.oe_n;
  assign BUSY          = s_q.busy;
  assign SKIP          = s_q.skip;

  property p_oe_q4;
    @(posedge CLOCK) disable iff (!ARST_N)
      !OE_N |-> (ph.phase == tnx_pkg::TNX_Q4) && (ADDR_BUS == TABLE_POINTER);
  endproperty
  a_oe_q4: assert property (p_oe_q4) else $error("enable outside Q4");

  property p_swap;
    @(posedge CLOCK) disable iff (!ARST_N)
      (ph.phase == tnx_pkg::TNX_Q4 && s_q.mode == tnx_pkg::TNX_EXEC && is_swap)
      |-> s_q.res == {s_q.opnd[3:0], s_q.opnd[7:4]};
  endproperty
  a_swap: assert property (p_swap) else $error("swap result wrong");

  property p_swap_w;
    @(posedge CLOCK) disable iff (!ARST_N)
      (ph.phase == tnx_pkg::TNX_Q4 && s_q.mode == tnx_pkg::TNX_EXEC && is_swap
       && !s_q.ir[tnx_pkg::TNX_BIT_D]) |=> (WORKING_REGISTER == $past(s_q.res)) && !FILE_WE;
  endproperty
  a_swap_w: assert property (p_swap_w) else $error("swap dest wrong");

  property p_tlw;
    @(posedge CLOCK) disable iff (!ARST_N)
      (ph.phase == tnx_pkg::TNX_Q3 && s_q.mode == tnx_pkg::TNX_EXEC && is_tlw
       && !s_q.ir[tnx_pkg::TNX_BIT_T]) |=> TABLE_LATCH[15:8] == $past(s_q.latch[15:8]);
  endproperty
  a_tlw: assert property (p_tlw) else $error("latch half disturbed");

  property p_tlw_nowr;
    @(posedge CLOCK) disable iff (!ARST_N)
      (ph.phase == tnx_pkg::TNX_Q4 && s_q.mode == tnx_pkg::TNX_EXEC && is_tlw) |=> !FILE_WE;
  endproperty
  a_tlw_nowr: assert property (p_tlw_nowr) else $error("latch write wrote file");

  // Busy covers exactly one extra cycle, then drops for the next decode
  sequence s_busy_one_cycle;
    BUSY [*4] ##1 !BUSY;
  endsequence

  // Counter low destination costs a second extra cycle
  sequence s_busy_two_cycles;
    BUSY [*8] ##1 !BUSY;
  endsequence

  // Skip flag marks only the flushed cycle
  sequence s_skip_one_cycle;
    SKIP [*4] ##1 !SKIP;
  endsequence

  property p_trd_len;
    @(posedge CLOCK) disable iff (!ARST_N)
      (ph.phase == tnx_pkg::TNX_Q4 && s_q.mode == tnx_pkg::TNX_EXEC && is_trd
       && s_q.faddr != tnx_pkg::TNX_ADDR_PCL) |=> s_busy_one_cycle;
  endproperty
  a_trd_len: assert property (p_trd_len) else $error("table read length");

  property p_trd_pcl_len;
    @(posedge CLOCK) disable iff (!ARST_N)
      (ph.phase == tnx_pkg::TNX_Q4 && s_q.mode == tnx_pkg::TNX_EXEC && is_trd
       && s_q.faddr == tnx_pkg::TNX_ADDR_PCL) |=> s_busy_two_cycles;
  endproperty
  a_trd_pcl_len: assert property (p_trd_pcl_len) else $error("counter low read length");

  property p_ptr_inc;
    @(posedge CLOCK) disable iff (!ARST_N)
      (s_q.mode == tnx_pkg::TNX_TBL && ph.phase == tnx_pkg::TNX_Q4)
      |=> TABLE_POINTER == $past(s_q.ptr) + ($past(s_q.ir[tnx_pkg::TNX_BIT_I]) ?
          tnx_pkg::TNX_PTR_STEP : tnx_pkg::TNX_WORD_RESET);
  endproperty
  a_ptr_inc: assert property (p_ptr_inc) else $error("pointer step wrong");

  property p_latch_load;
    @(posedge CLOCK) disable iff (!ARST_N)
      (s_q.mode == tnx_pkg::TNX_TBL && ph.phase == tnx_pkg::TNX_Q4)
      |=> TABLE_LATCH == $past(PMEM_RDATA);
  endproperty
  a_latch_load: assert property (p_latch_load) else $error("latch not loaded");

  property p_skip;
    @(posedge CLOCK) disable iff (!ARST_N)
      (ph.phase == tnx_pkg::TNX_Q4 && s_q.mode == tnx_pkg::TNX_EXEC && is_tst
       && s_q.opnd == tnx_pkg::TNX_ZERO_BYTE) |=> SKIP && BUSY;
  endproperty
  a_skip: assert property (p_skip) else $error("skip missed");

  property p_skip_len;
    @(posedge CLOCK) disable iff (!ARST_N)
      (ph.phase == tnx_pkg::TNX_Q4 && s_q.mode == tnx_pkg::TNX_EXEC && is_tst
       && s_q.opnd == tnx_pkg::TNX_ZERO_BYTE) |=> s_skip_one_cycle;
  endproperty
  a_skip_len: assert property (p_skip_len) else $error("skip length wrong");
endmodule : tnx_exec

// ---- rtl/tnx_phase_gen.sv ----
// Four-phase sequencer, one phase per oscillator period
`timescale 1ns/1ps
module tnx_phase_gen (
  input wire logic CLOCK,
  input wire logic ARST_N,
  tnx_phase_if.gen ph
);
  typedef struct packed {
    tnx_pkg::tnx_phase_type phase;
  } tnx_pg_state_type;

  tnx_pg_state_type s_q;
  tnx_pg_state_type s_d;

  // Advance one phase per clock and wrap after the fourth
  always_comb begin
    s_d = s_q;
    case (s_q.phase)
      tnx_pkg::TNX_Q1: s_d.phase = tnx_pkg::TNX_Q2;
      tnx_pkg::TNX_Q2: s_d.phase = tnx_pkg::TNX_Q3;
      tnx_pkg::TNX_Q3: s_d.phase = tnx_pkg::TNX_Q4;
      tnx_pkg::TNX_Q4: s_d.phase = tnx_pkg::TNX_Q1;
      default:         s_d.phase = tnx_pkg::TNX_Q1;
    endcase
  end

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      s_q.phase <= tnx_pkg::TNX_Q1;
    end else begin
      s_q <= s_d;
    end
  end

  assign ph.phase     = s_q.phase;
  assign ph.cycle_end = (s_q.phase == tnx_pkg::TNX_Q4);

  // Remaining phases of one cycle, back to the next decode phase
  sequence s_q2_to_q1;
    (s_q.phase == tnx_pkg::TNX_Q2) ##1 (s_q.phase == tnx_pkg::TNX_Q3) ##1
    (s_q.phase == tnx_pkg::TNX_Q4) ##1 (s_q.phase == tnx_pkg::TNX_Q1);
  endsequence

  property p_phase_wrap;
    @(posedge CLOCK) disable iff (!ARST_N)
      (s_q.phase == tnx_pkg::TNX_Q1) |=> s_q2_to_q1;
  endproperty
  a_phase_wrap: assert property (p_phase_wrap) else $error("phase order broken");
endmodule : tnx_phase_gen

// ---- rtl/tnx_phase_if.sv ----
// Interface carrying the phase timing between the sequencer and the executor
`timescale 1ns/1ps
interface tnx_phase_if;
  tnx_pkg::tnx_phase_type phase;
  logic                   cycle_end;
  modport gen (output phase, output cycle_end);
  modport use_ (input phase, input cycle_end);
endinterface : tnx_phase_if

// ---- rtl/tnx_pkg.sv ----
// Package with opcodes, field positions and phase encodings for the executor
package tnx_pkg;
  localparam int          TNX_PHASES       = 4;
  localparam logic [6:0]  TNX_OPC_SWAP     = 7'h0E;  // 0001 110
  localparam logic [5:0]  TNX_OPC_TRD      = 6'h2A;  // 1010 10
  localparam logic [5:0]  TNX_OPC_TLW      = 6'h29;  // 1010 01
  localparam logic [7:0]  TNX_OPC_TST      = 8'h33;  // 0011 0011
  localparam int          TNX_BIT_D        = 8;
  localparam int          TNX_BIT_T        = 9;
  localparam int          TNX_BIT_I        = 8;
  localparam logic [7:0]  TNX_ADDR_PCL     = 8'h02;  // Register file address of program_counter_low
  localparam logic [7:0]  TNX_ZERO_BYTE    = 8'h00;
  localparam logic [15:0] TNX_PTR_STEP     = 16'h0001;
  localparam logic [7:0]  TNX_WORKING_REGISTER_RESET   = 8'h00;
  localparam logic [15:0] TNX_WORD_RESET   = 16'h0000;

  typedef enum logic [1:0] {
    TNX_Q1,
    TNX_Q2,
    TNX_Q3,
    TNX_Q4
  } tnx_phase_type;

  typedef enum logic [1:0] {
    TNX_EXEC,
    TNX_TBL,
    TNX_FLUSH
  } tnx_mode_type;
endpackage : tnx_pkg

// ---- test/tb_top.sv ----
// Self-checking bench for the table and nibble executor
`timescale 1ns/1ps
module tb_top;
  logic        clock = 1'b0;
  logic        arst_n = 1'b0;
  logic [15:0] instr = 16'h0000;
  logic        instr_valid = 1'b0;
  logic [7:0]  file_rdata, file_addr, file_wdata, working_register;
  logic [15:0] pmem_rdata, tbl_latch, tbl_ptr, addr_bus;
  logic        file_re, file_we, oe_n, busy, skip;
  int          n_fail = 0;
  int          num_checks = 0;
  int          nb, ns, oe0;

  always #50 clock = ~clock;

  tnx_exec tnx_exec_inst (.CLOCK(clock), .ARST_N(arst_n), .INSTR(instr),
    .INSTR_VALID(instr_valid), .FILE_RDATA(file_rdata), .PMEM_RDATA(pmem_rdata),
    .FILE_ADDR(file_addr), .FILE_RE(file_re), .FILE_WE(file_we), .FILE_WDATA(file_wdata),
    .WORKING_REGISTER(working_register), .TABLE_LATCH(tbl_latch), .TABLE_POINTER(tbl_ptr), .ADDR_BUS(addr_bus),
    .OE_N(oe_n), .BUSY(busy), .SKIP(skip));

  tnx_mem_model tnx_mem_model_inst (.CLOCK(clock), .FILE_ADDR(file_addr),
    .FILE_RE(file_re), .FILE_WE(file_we), .FILE_WDATA(file_wdata),
    .ADDR_BUS(addr_bus), .OE_N(oe_n), .FILE_RDATA(file_rdata), .PMEM_RDATA(pmem_rdata));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  function automatic logic [15:0] rf(input logic [7:0] a);
    return {8'h00, tnx_mem_model_inst.regs[a]};
  endfunction : rf

  // Issue one word just before a Q1 edge and count busy and skip over n instruction cycles.
  // One idle nop cycle follows, so a file write launched in the last Q4 has landed and the
  // next call again starts just before a Q1 edge.
  task automatic exec(input logic [15:0] word, input int n);
    nb = 0;
    ns = 0;
    instr = word;
    instr_valid = 1'b1;
    repeat (4 * n) begin
      @(negedge clock);
      instr_valid = 1'b0;
      nb += (busy === 1'b1);
      ns += (skip === 1'b1);
    end
    repeat (4) @(negedge clock);
  endtask : exec

  task automatic t_reset();
    chk({8'h00, working_register}, 16'h0000);
    chk(tbl_latch, 16'h0000);
    chk(tbl_ptr, 16'h0000);
    chk({15'h0000, oe_n}, 16'h0001);
    $display("reset test done");
  endtask : t_reset

  task automatic t_swap();
    tnx_mem_model_inst.regs[8'h10] = 8'h53;
    tnx_mem_model_inst.regs[8'hFF] = 8'hA7;
    exec(16'h1C10, 1);
    chk({8'h00, working_register}, 16'h0035);
    chk(rf(8'h10), 16'h0053);
    chk(16'(nb), 16'h0000);
    exec(16'h1DFF, 1);
    chk(rf(8'hFF), 16'h007A);
    chk({8'h00, working_register}, 16'h0035);
    $display("swap test done");
  endtask : t_swap

  // Low half first, then high half twice, the second time with the don't-care bit set
  task automatic t_latch();
    tnx_mem_model_inst.regs[8'h20] = 8'hB7;
    tnx_mem_model_inst.regs[8'h21] = 8'hC4;
    tnx_mem_model_inst.regs[8'h22] = 8'h9E;
    exec(16'hA420, 1);
    chk(tbl_latch, 16'h00B7);
    exec(16'hA621, 1);
    chk(tbl_latch, 16'hC4B7);
    chk(16'(nb), 16'h0000);
    chk(rf(8'h21), 16'h00C4);
    exec(16'hA722, 1);
    chk(tbl_latch, 16'h9EB7);
    $display("latch write test done");
  endtask : t_latch

  // Pointer starts at zero, so the word fetched is the model's pattern at 0 then 1
  task automatic t_tread();
    oe0 = tnx_mem_model_inst.oe_cnt;
    exec(16'hAB30, 2);
    chk(rf(8'h30), 16'h009E);
    chk(tbl_latch, 16'h5A3C);
    chk(tbl_ptr, 16'h0001);
    chk(16'(nb), 16'h0004);
    chk(16'(tnx_mem_model_inst.oe_cnt - oe0), 16'h0001);
    chk(tnx_mem_model_inst.oe_addr, 16'h0000);
    exec(16'hA831, 2);
    chk(rf(8'h31), 16'h003C);
    chk(tbl_latch, 16'h5A3D);
    chk(tbl_ptr, 16'h0001);
    exec(16'hA802, 3);
    chk(16'(nb), 16'h0008);
    chk(rf(8'h02), 16'h003D);
    $display("table read test done");
  endtask : t_tread

  task automatic t_skip();
    tnx_mem_model_inst.regs[8'h40] = 8'h00;
    tnx_mem_model_inst.regs[8'h41] = 8'h01;
    exec(16'h3340, 2);
    chk(16'(nb), 16'h0004);
    chk(16'(ns), 16'h0004);
    exec(16'h3341, 1);
    chk(16'(nb + ns), 16'h0000);
    $display("skip test done");
  endtask : t_skip

  task automatic close_out();
    $display("checks=%0d mismatches=%0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : close_out

  // Watchdog: the tests need about 110 cycles
  initial begin
    #200000;
    n_fail++;
    close_out();
  end

  initial begin
    repeat (12) @(posedge clock);
    @(negedge clock);
    arst_n = 1'b1;
    t_reset();
    t_swap();
    t_latch();
    t_tread();
    t_skip();
    close_out();
  end
endmodule : tb_top

// ---- test/tnx_mem_model.sv ----
// Partner model: register file and program memory behind the executor
`timescale 1ns/1ps
module tnx_mem_model (
  input  wire logic        CLOCK,
  input  wire logic [7:0]  FILE_ADDR,
  input  wire logic        FILE_RE,
  input  wire logic        FILE_WE,
  input  wire logic [7:0]  FILE_WDATA,
  input  wire logic [15:0] ADDR_BUS,
  input  wire logic        OE_N,
  output logic      [7:0]  FILE_RDATA,
  output logic      [15:0] PMEM_RDATA
);
  logic [7:0]  regs [256];
  logic [7:0]  rd_last_q = 8'h00;
  logic [15:0] pm_last_q = 16'h0000;
  int          oe_cnt = 0;
  logic [15:0] oe_addr = 16'h0000;
  // Idle outputs show the inverse of the last value, so stale data never looks valid
  assign FILE_RDATA = FILE_RE ? regs[FILE_ADDR] : ~rd_last_q;
  assign PMEM_RDATA = !OE_N ? (ADDR_BUS ^ 16'h5A3C) : ~pm_last_q;
  // Writes and bus accesses are taken on the sampling edge
  always @(posedge CLOCK) begin
    rd_last_q <= FILE_RDATA;
    pm_last_q <= PMEM_RDATA;
    if (FILE_WE === 1'b1) begin
      regs[FILE_ADDR] <= FILE_WDATA;
    end
    if (OE_N === 1'b0) begin
      oe_cnt  <= oe_cnt + 1;
      oe_addr <= ADDR_BUS;
    end
  end
endmodule : tnx_mem_model
